// ---- verilog/kef_consts.svh ----
`ifndef KEF_CONSTS_SVH
`define KEF_CONSTS_SVH
// Functional notes
// - queue byte holds key code in bits 5:0, release bit 6, more bit 7.
// - bit 7 set when more entries remain after the one read, else clear.
// - bit 6 set for key release, clear for key press.
// - empty reads 0x3F; overflow reads 0x7F and host keeps reading.
// - key 63 events report bit 7 high, code 0x3F, bit 6 release flag.
// - autorepeat is code 0x3E, bit 7 low, bit 6 means more entries follow.
// - key 62 events report bit 7 high, code 0x3E, bit 6 release flag.
// - while constant-current PWM enabled, key scan stays operating.
// - with PWM off, host, autosleep and autowake update config bit 7.
// - config bit 7 readable anytime, shows current sleep state.
// - with config bit 5 low, interrupt clears only once queue emptied.
// - pointer advances in multi-byte access, but not at queue address.
`define KEF_ADDR_QUEUE   8'h00
`define KEF_ADDR_CONFIG  8'h01
`define KEF_DEPTH        16
`define KEF_CODE_SPECIAL 6'h3F
`define KEF_CODE_REPEAT  6'h3E
`define KEF_BYTE_EMPTY   8'h3F
`define KEF_BYTE_OVFL    8'h7F
`define KEF_CFG_SLEEP    7
`define KEF_CFG_INTMODE  5
`define KEF_CFG_RESET    8'h00
`define KEF_CFG_WMASK    8'hAF
`endif

// ---- verilog/kef_pkg.sv ----
package kef_pkg;
   typedef enum logic [1:0] {
      KEF_RD_IDLE  = 2'b00,
      KEF_RD_KEY   = 2'b01,
      KEF_RD_SPILL = 2'b10
   } kef_rd_e;
   typedef logic [6:0] kef_entry_t;
endpackage

// ---- verilog/kef_queue.sv ----
`timescale 1ns/100ps
`include "kef_consts.svh"
module kef_queue (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // key events from debounce
   input  wire logic       evt_valid,
   input  wire logic [5:0] evt_code,
   input  wire logic       evt_release,
   input  wire logic       evt_repeat,
   // register port from serial slave
   input  wire logic       reg_rd,
   input  wire logic       reg_wr,
   input  wire logic       reg_burst,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic      [7:0] reg_ptr,
   // control from and to other blocks
   input  wire logic       pwm_cc_en,
   input  wire logic       auto_sleep,
   input  wire logic       auto_wake,
   input  wire logic       int_cond,
   output logic            key_int,
   output logic            scan_active,
   output logic      [4:0] fill_level
);
   // ****************************************
   // storage
   // ****************************************
   kef_pkg::kef_entry_t mem_ff [`KEF_DEPTH];
   logic                rep_ff [`KEF_DEPTH];
   logic [3:0]          wp_ff;
   logic [3:0]          rp_ff;
   logic [4:0]          cnt_ff;
   logic                ovf_ff;
   logic [7:0]          cfg_ff;
   logic [7:0]          rdata_ff;
   logic [7:0]          ptr_ff;
   logic                int_ff;
   logic                q_rd;
   logic                cfg_hit;
   logic                cfg_wr;
   logic                any_acc;
   logic                pop;
   logic                push;
   logic                drop;
   logic                full;
   logic                empty;
   logic                last_entry;
   logic                flush;
   logic                head_rep;
   logic [7:0]          key_byte;
   logic [7:0]          queue_byte;
   logic [7:0]          nxt_rdata;
   logic [7:0]          nxt_ptr;
   logic [7:0]          nxt_cfg;
   logic                nxt_int;
   kef_pkg::kef_rd_e    rd_kind;
   kef_pkg::kef_entry_t head;
   kef_pkg::kef_entry_t new_entry;

   // ****************************************
   // register decode
   // ****************************************
   assign q_rd    = reg_rd && (reg_addr == `KEF_ADDR_QUEUE);
   assign cfg_hit = (reg_addr == `KEF_ADDR_CONFIG);
   assign cfg_wr  = reg_wr && cfg_hit;
   assign any_acc = reg_rd || reg_wr;

   // ****************************************
   // queue status
   // ****************************************
   assign empty      = (cnt_ff == 5'h00);
   assign full       = (cnt_ff == 5'(`KEF_DEPTH));
   assign last_entry = (cnt_ff == 5'h01);
   assign flush      = !scan_active;
   assign pop        = q_rd && !empty && !ovf_ff;

   // ****************************************
   // event accept
   // ****************************************
   assign push      = evt_valid && !full && scan_active;
   assign drop      = evt_valid && full && scan_active;
   assign new_entry = {evt_release, evt_code};

   // ****************************************
   // head entry
   // ****************************************
   assign head     = mem_ff[rp_ff];
   assign head_rep = rep_ff[rp_ff];

   // ****************************************
   // write pointer
   // ****************************************
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wp_ff <= 4'h0;
      end else if (flush) begin
         wp_ff <= 4'h0;
      end else if (push) begin
         wp_ff <= wp_ff + 4'h1;
      end
   end

   // ****************************************
   // read pointer
   // ****************************************
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rp_ff <= 4'h0;
      end else if (flush) begin
         rp_ff <= 4'h0;
      end else if (pop) begin
         rp_ff <= rp_ff + 4'h1;
      end
   end

   // ****************************************
   // fill count
   // ****************************************
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 5'h00;
      end else if (flush) begin
         cnt_ff <= 5'h00;
      end else begin
         cnt_ff <= cnt_ff + 5'(push) - 5'(pop);
      end
   end

   // ****************************************
   // entry storage
   // ****************************************
   always_ff @(posedge clock) begin
      if (push) begin
         mem_ff[wp_ff] <= new_entry;
         rep_ff[wp_ff] <= evt_repeat;
      end
   end

   // ****************************************
   // overflow marker
   // ****************************************
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ovf_ff <= 1'b0;
      end else if (drop) begin
         ovf_ff <= 1'b1;
      end else if (flush) begin
         ovf_ff <= 1'b0;
      end else if (q_rd) begin
         ovf_ff <= 1'b0;
      end
   end

   // ****************************************
   // read kind select
   // ****************************************
   always_comb begin
      rd_kind = kef_pkg::KEF_RD_KEY;
      if (ovf_ff) begin
         rd_kind = kef_pkg::KEF_RD_SPILL;
      end else if (empty) begin
         rd_kind = kef_pkg::KEF_RD_IDLE;
      end
   end

   // ****************************************
   // key entry encode
   // ****************************************
   always_comb begin
      key_byte = {!last_entry, head};
      if (head_rep) begin
         key_byte = {1'b0, !last_entry, `KEF_CODE_REPEAT};
      end else if (head[5:0] == `KEF_CODE_SPECIAL) begin
         key_byte = {1'b1, head};
      end else if (head[5:0] == `KEF_CODE_REPEAT) begin
         key_byte = {1'b1, head};
      end
   end

   // ****************************************
   // queue read byte
   // ****************************************
   always_comb begin
      case (rd_kind)
         kef_pkg::KEF_RD_IDLE: begin
            queue_byte = `KEF_BYTE_EMPTY;
         end
         kef_pkg::KEF_RD_SPILL: begin
            queue_byte = `KEF_BYTE_OVFL;
         end
         kef_pkg::KEF_RD_KEY: begin
            queue_byte = key_byte;
         end
         default: begin
            queue_byte = `KEF_BYTE_EMPTY;
         end
      endcase
   end

   // ****************************************
   // read data
   // ****************************************
   always_comb begin
      nxt_rdata = rdata_ff;
      if (reg_rd) begin
         if (reg_addr == `KEF_ADDR_QUEUE) begin
            nxt_rdata = queue_byte;
         end else if (cfg_hit) begin
            nxt_rdata = cfg_ff;
         end else begin
            nxt_rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ****************************************
   // configuration register
   // ****************************************
   always_comb begin
      nxt_cfg = cfg_ff;
      if (cfg_wr) begin
         nxt_cfg = reg_wdata & `KEF_CFG_WMASK;
      end
      if (pwm_cc_en) begin
         nxt_cfg[`KEF_CFG_SLEEP] = 1'b1;
      end else if (auto_wake) begin
         nxt_cfg[`KEF_CFG_SLEEP] = 1'b1;
      end else if (auto_sleep) begin
         nxt_cfg[`KEF_CFG_SLEEP] = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff <= `KEF_CFG_RESET;
      end else begin
         cfg_ff <= nxt_cfg;
      end
   end

   assign scan_active = cfg_ff[`KEF_CFG_SLEEP] || pwm_cc_en;

   // ****************************************
   // register pointer
   // ****************************************
   always_comb begin
      nxt_ptr = ptr_ff;
      if (any_acc) begin
         nxt_ptr = reg_addr;
         if (reg_burst && reg_addr != `KEF_ADDR_QUEUE) begin
            nxt_ptr = reg_addr + 8'h01;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ptr_ff <= 8'h00;
      end else begin
         ptr_ff <= nxt_ptr;
      end
   end

   // ****************************************
   // interrupt hold
   // ****************************************
   always_comb begin
      nxt_int = int_ff;
      if (int_cond) begin
         nxt_int = 1'b1;
      end else if (!cfg_ff[`KEF_CFG_INTMODE]) begin
         if (empty && !ovf_ff) begin
            nxt_int = 1'b0;
         end
      end else if (q_rd) begin
         nxt_int = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         int_ff <= 1'b0;
      end else begin
         int_ff <= nxt_int;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign key_int    = int_ff;
   assign reg_rdata  = rdata_ff;
   assign reg_ptr    = ptr_ff;
   assign fill_level = cnt_ff;
endmodule // kef_queue

// ---- dv/kef_props.sv ----
`timescale 1ns/100ps
// **********
// queue checks
// **********
module kef_props (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic       evt_valid,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic       pwm_cc_en,
   input wire logic       scan_active,
   input wire logic [4:0] fill_level
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic qrd;
   assign qrd = reg_rd && reg_addr == 8'h00 && !evt_valid;
   AST_PWM: assert property (pwm_cc_en |-> scan_active)
      else $error("scan off with pwm on");
   AST_MAX: assert property (fill_level <= 5'h10)
      else $error("fill above depth");
   AST_PUSH: assert property (evt_valid && !reg_rd && scan_active
      && fill_level < 5'h10 |=> fill_level == $past(fill_level) + 5'h01)
      else $error("push not counted");
   AST_POP: assert property (qrd && scan_active
      && fill_level inside {[5'h01:5'h0F]}
      |=> fill_level == $past(fill_level) - 5'h01)
      else $error("read did not pop one");
   AST_EMPTY: assert property (qrd && fill_level == 5'h00
      |=> reg_rdata == 8'h3F && fill_level == 5'h00)
      else $error("bad empty read");
   AST_LAST: assert property (qrd && fill_level == 5'h01
      |=> !reg_rdata[7] || reg_rdata[5:1] == 5'h1F)
      else $error("more flag on last entry");
   AST_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved");
   AST_CFG: assert property (reg_rd && reg_addr == 8'h01
      |=> reg_rdata[6] == 1'h0 && reg_rdata[4] == 1'h0)
      else $error("reserved config bits set");
endmodule // kef_props
bind kef_queue kef_props u_props (.*);

// ---- dv/kef_host.sv ----
`timescale 1ns/100ps
// **********
// host model
// **********
module kef_host (
   // clock
   input wire logic       clock,
   // register port
   output logic           reg_rd,
   output logic           reg_wr,
   output logic           reg_burst,
   output logic     [7:0] reg_addr,
   output logic     [7:0] reg_wdata
);
   initial begin
      reg_rd = 1'h0;
      reg_wr = 1'h0;
      reg_burst = 1'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   task automatic acc(input logic w, input logic [7:0] a, d,
                      input logic b = 1'h0);
      @(negedge clock);
      reg_rd = !w;
      reg_wr = w;
      reg_burst = b;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clock);
      reg_rd = 1'h0;
      reg_wr = 1'h0;
      reg_burst = 1'h0;
   endtask
endmodule // kef_host

// ---- dv/tb.sv ----
`timescale 1ns/100ps
// **********
// bench
// **********
module tb;
   logic       clock, rst_n, evt_valid, evt_release, evt_repeat;
   logic       reg_rd, reg_wr, reg_burst, pwm_cc_en, auto_sleep;
   logic       auto_wake, int_cond, key_int, scan_active;
   logic [5:0] evt_code;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, reg_ptr;
   logic [4:0] fill_level;
   int         fails = 0;
   int         checks_done = 0;
   kef_queue DUT (.*);
   kef_host u_host (.*);
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   task automatic chk(input string n, input logic [7:0] s, e);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd(input logic [7:0] a, e, input string n);
      u_host.acc(1'h0, a, 8'h00);
      chk(n, reg_rdata, e);
   endtask
   task automatic push(input logic [5:0] c, input logic r, p);
      @(negedge clock);
      evt_valid = 1'h1;
      evt_code = c;
      evt_release = r;
      evt_repeat = p;
      @(negedge clock);
      evt_valid = 1'h0;
   endtask
   task automatic pulse(input int k);
      @(negedge clock);
      {int_cond, auto_wake, auto_sleep} = 3'(1 << k);
      @(negedge clock);
      {int_cond, auto_wake, auto_sleep} = 3'h0;
   endtask
   task automatic results;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      {rst_n, evt_valid, evt_release, evt_repeat} = 4'h0;
      {pwm_cc_en, auto_sleep, auto_wake, int_cond} = 4'h0;
      evt_code = 6'h00;
      repeat (2) @(negedge clock);
      rst_n = 1'h1;
      rd(8'h01, 8'h00, "cfg");
      rd(8'h00, 8'h3F, "empty");
      u_host.acc(1'h1, 8'h01, 8'h80);
      rd(8'h01, 8'h80, "cfg");
      push(6'h05, 1'h0, 1'h0);
      push(6'h06, 1'h1, 1'h0);
      rd(8'h00, 8'h85, "q");
      rd(8'h00, 8'h46, "q");
      rd(8'h00, 8'h3F, "q");
      push(6'h3F, 1'h1, 1'h0);
      push(6'h3E, 1'h0, 1'h0);
      push(6'h3E, 1'h0, 1'h1);
      rd(8'h00, 8'hFF, "q");
      rd(8'h00, 8'hBE, "q");
      rd(8'h00, 8'h3E, "q");
      push(6'h3E, 1'h0, 1'h1);
      push(6'h09, 1'h0, 1'h0);
      chk("fill", {3'h0, fill_level}, 8'h02);
      rd(8'h00, 8'h7E, "rep");
      rd(8'h00, 8'h09, "q");
      push(6'h01, 1'h0, 1'h0);
      pulse(2);
      chk("int", {7'h00, key_int}, 8'h01);
      rd(8'h00, 8'h01, "q");
      chk("int", {7'h00, key_int}, 8'h01);
      @(negedge clock);
      chk("int", {7'h00, key_int}, 8'h00);
      u_host.acc(1'h1, 8'h01, 8'hA0);
      rd(8'h01, 8'hA0, "cfg");
      push(6'h02, 1'h0, 1'h0);
      pulse(2);
      chk("int", {7'h00, key_int}, 8'h01);
      rd(8'h00, 8'h02, "q");
      chk("int", {7'h00, key_int}, 8'h00);
      u_host.acc(1'h1, 8'h01, 8'h80);
      u_host.acc(1'h0, 8'h01, 8'h00, 1'h1);
      chk("ptr", reg_ptr, 8'h02);
      u_host.acc(1'h0, 8'h00, 8'h00, 1'h1);
      chk("ptr", reg_ptr, 8'h00);
      for (int i = 0; i < 17; i++) push(i[5:0], 1'h0, 1'h0);
      rd(8'h00, 8'h7F, "ovfl");
      for (int i = 0; i < 16; i++) begin
         rd(8'h00, {i < 15, 1'h0, i[5:0]}, "q");
      end
      pwm_cc_en = 1'h1;
      u_host.acc(1'h1, 8'h01, 8'h00);
      chk("scan", {7'h00, scan_active}, 8'h01);
      pwm_cc_en = 1'h0;
      u_host.acc(1'h1, 8'h01, 8'h00);
      rd(8'h01, 8'h00, "cfg");
      chk("scan", {7'h00, scan_active}, 8'h00);
      push(6'h05, 1'h0, 1'h0);
      chk("fill", {3'h0, fill_level}, 8'h00);
      pulse(1);
      rd(8'h01, 8'h80, "cfg");
      pulse(0);
      rd(8'h01, 8'h00, "cfg");
      results;
   end
   initial begin
      #20000;
      fails++;
      results;
   end
endmodule // tb
